/* hdl/dgoc_pkg.sv */
// Constants shared by the DAC gain and offset correction block.
// Assumes a 32-bit APB slave port with 12 address bits.
package dgoc_pkg;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam logic [15:0] GAIN_DEF = 16'hFFFF;
  localparam logic [15:0] OFFS_DEF = 16'h8000;
  localparam logic signed [18:0] OFFS_ZERO = 19'sh08000;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam int N_SET = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] CODE_BASE = 12'h100;
  localparam logic [11:0] DUAL_BASE = 12'h180;
  localparam logic [11:0] GAIN_BASE = 12'h200;
  localparam logic [11:0] OFFS_BASE = 12'h300;

  // Control register fields.
  localparam int CTRL_CAL_EN = 0;
  localparam int CTRL_DEFER0 = 1;
  localparam int CTRL_LOAD0 = 4;
  localparam logic CAL_EN_RST = 1'b0;
  localparam logic DEFER_RST = 1'b0;

  // Status register fields.
  localparam int STAT_PEND0 = 0;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} dgoc_state_t;

endpackage

/* hdl/dgoc_corr.sv */
// Gain and offset arithmetic for one code, one result per issue.
// Assumes coefficients and the raw code are stable in the issue cycle.
`timescale 1ns/1ns
module dgoc_corr
  import dgoc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  input wire logic bypass_i,
  input wire logic [15:0] raw_code_i,
  input wire logic [15:0] m_i,
  input wire logic [15:0] c_i,
  output logic out_valid_o,
  output logic [15:0] code_o
);

  logic [16:0] gain_p1;
  logic [32:0] prod;
  logic signed [18:0] sum;
  logic [15:0] next_code;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // [RQ6] scaled gain plus offset
  // The product never exceeds 65536 * 65535, so bits above 31 stay zero.
  always_comb begin
    gain_p1 = {1'b0, m_i} + 17'h00001;
    prod = 33'(gain_p1) * 33'(raw_code_i);
    sum = $signed({3'h0, prod[31:16]}) + $signed({3'h0, c_i}) - OFFS_ZERO;
    // [RQ18] clamp instead of wrap
    if (sum < 0) begin
      next_code = CODE_MIN;
    end else if (sum > $signed({3'h0, CODE_MAX})) begin
      next_code = CODE_MAX;
    end else begin
      next_code = sum[15:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      code_o <= CODE_MIN;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        // [RQ17] bypass stores raw code
        code_o <= bypass_i ? raw_code_i : next_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_bypass_raw: assert property ( // RQ17
    @(posedge sys_clk_i) disable iff (!resetn_i)
    in_valid_i && bypass_i |=> out_valid_o && code_o == $past(raw_code_i))
    else $error("bypassed result differs from raw code");

  chk_unity_gain: assert property ( // RQ7
    @(posedge sys_clk_i) disable iff (!resetn_i)
    in_valid_i && !bypass_i && m_i == GAIN_DEF && c_i == OFFS_DEF |=> code_o == $past(raw_code_i))
    else $error("default coefficients do not give unity");

  chk_sat_low: assert property ( // RQ18
    @(posedge sys_clk_i) disable iff (!resetn_i)
    in_valid_i && !bypass_i && m_i == GAIN_DEF && c_i == 16'h0000 && raw_code_i < 16'h8000 |=> code_o == CODE_MIN)
    else $error("underflow not clamped to zero");

  chk_sat_high: assert property ( // RQ18
    @(posedge sys_clk_i) disable iff (!resetn_i)
    in_valid_i && !bypass_i && m_i == GAIN_DEF && c_i == 16'hFFFF && raw_code_i > 16'h8000 |=> code_o == CODE_MAX)
    else $error("overflow not clamped to full scale");

  cov_saturate: cover property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    in_valid_i && !bypass_i && sum < 0);

endmodule

/* hdl/dgoc_update.sv */
// Analog update scheduling for one channel bank.
// Assumes done_i arrives one cycle after the last result write of a sequence.
`timescale 1ns/1ns
module dgoc_update (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic wr_i,
  input wire logic imm_i,
  input wire logic done_i,
  input wire logic load_i,
  output logic xfer_o,
  output logic pend_o
);

  logic xfer_now;

  // [RQ15] deferred waits for load
  // [RQ16] immediate follows write end
  assign xfer_now = pend_o && (imm_i ? done_i : load_i);

  // A result written in the same cycle as a transfer keeps the flag set.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_o <= 1'b0;
    end else if (wr_i) begin
      pend_o <= 1'b1;
    end else if (xfer_now) begin
      pend_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xfer_o <= 1'b0;
    end else begin
      xfer_o <= xfer_now;
    end
  end

  chk_defer_hold: assert property ( // RQ15
    @(posedge sys_clk_i) disable iff (!resetn_i)
    xfer_o && !$past(imm_i) |-> $past(load_i) && $past(pend_o))
    else $error("deferred transfer without load request");

  chk_imm_xfer: assert property ( // RQ16
    @(posedge sys_clk_i) disable iff (!resetn_i)
    done_i && imm_i && pend_o |=> xfer_o ##1 !pend_o || $past(wr_i))
    else $error("immediate transfer did not follow write end");

  cov_deferred: cover property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    pend_o && !imm_i ##[1:50] xfer_o);

endmodule

/* hdl/dgoc_top.sv */
// DAC code calibration block: APB registers, coefficient store, results.
// Assumes an APB master on sys_clk_i; DAC outputs feed the analog update
// and deglitch logic, which samples dac_code_o when dac_load_o pulses.
`timescale 1ns/1ns

// Notes on behaviour
// [RQ1] Every DAC function has its own gain and offset coefficient word.
// [RQ2] Coefficients are volatile; host reloads non-default values after power-up.
// [RQ3] No reset clears or alters coefficient storage.
// [RQ4] Reset clears calibration enable, so correction is bypassed afterwards.
// [RQ5] Calibration bypass applies to all DACs at once, never a subset.
// [RQ6] Corrected = (gain+1)/65536 times raw code plus offset minus 32768.
// [RQ7] Gain defaults to 0xFFFF and offset to 0x8000: unity, zero shift.
// [RQ8] One result register per DAC, moved to the DAC at analog update.
// [RQ9] Reading a DAC returns its stored corrected code, not the raw code.
// [RQ10] Dual-channel write updates channel 0 then channel 1, own coefficients.
// [RQ11] A result is recomputed only when a new raw code is written.
// [RQ12] Coefficient or mode writes leave existing results unchanged.
// [RQ13] Host rewrites the code after changing coefficients or mode.
// [RQ14] Coefficient set is chosen from mode bits at code write time.
// [RQ15] Deferred mode holds the analog transfer until the load bit is set.
// [RQ16] Immediate mode transfers right after the write sequence ends.
// [RQ17] With calibration bypassed the raw code is stored unchanged.
// [RQ18] The corrected code saturates at 0x0000 and 0xFFFF.
module dgoc_top
  import dgoc_pkg::*;
#(
  parameter int N_DAC = 4
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [2*N_DAC*16-1:0] dac_code_o,
  output logic [1:0] dac_load_o
);

  // ----------------------------------------------------------------
  // Sizes and state
  // ----------------------------------------------------------------
  localparam int N_CH = 2;
  localparam int NX = N_CH * N_DAC;
  localparam int NC = N_SET * NX;
  localparam int DW = $clog2(N_DAC);
  localparam logic [4:0] NX5 = 5'(NX);
  localparam logic [4:0] ND5 = 5'(N_DAC);
  localparam logic [5:0] NC6 = 6'(NC);

  dgoc_state_t st;
  logic cal_en;
  logic [N_CH-1:0] defer;
  logic [NX-1:0] mode_sel;
  // [RQ2] power-up defaults, volatile
  // [RQ7] unity gain, zero offset
  // These words lose their contents at power-down; only the power-up
  // value is defined, so software must reload any trimmed value.
  logic [15:0] gain_mem [NC] = '{default: GAIN_DEF};
  logic [15:0] offs_mem [NC] = '{default: OFFS_DEF};
  logic [NX*16-1:0] corrected_code;

  logic [15:0] cap_raw;
  logic [DW-1:0] cap_dac;
  logic [N_CH-1:0] cap_mask;
  logic [NX-1:0] cap_sel;
  logic cap_cal;
  logic cur_ch;
  logic seq_done;

  logic acc_wr;
  logic hit_ctrl, hit_mode, hit_stat, hit_code, hit_dual, hit_gain, hit_offs;
  logic [4:0] aidx5;
  logic [5:0] aidx6;
  logic [31:0] rd_mux;
  logic code_wr;
  logic [N_CH-1:0] load_req;
  logic [N_CH-1:0] ch_wr;
  logic [N_CH-1:0] xfer;
  logic [N_CH-1:0] pend;

  logic c_in_valid;
  logic c_out_valid;
  logic [15:0] c_code;
  logic [15:0] sel_m;
  logic [15:0] sel_c;
  int sel_idx;
  int wr_slot;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign aidx5 = paddr_i[6:2];
  assign aidx6 = paddr_i[7:2];
  assign hit_ctrl = paddr_i == ADDR_CTRL;
  assign hit_mode = paddr_i == ADDR_MODE;
  assign hit_stat = paddr_i == ADDR_STAT;
  assign hit_code = paddr_i[11:7] == CODE_BASE[11:7] && aidx5 < NX5;
  assign hit_dual = paddr_i[11:7] == DUAL_BASE[11:7] && aidx5 < ND5;
  assign hit_gain = paddr_i[11:8] == GAIN_BASE[11:8] && aidx6 < NC6;
  assign hit_offs = paddr_i[11:8] == OFFS_BASE[11:8] && aidx6 < NC6;

  // A write takes effect only at the edge that completes the access.
  assign acc_wr = psel_i && penable_i && pready_o && pwrite_i;
  assign code_wr = acc_wr && (hit_code || hit_dual);
  assign load_req = acc_wr && hit_ctrl ? pwdata_i[CTRL_LOAD0 +: N_CH] : '0;

  // [RQ9] readback shows corrected code
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux = {29'h0, defer, cal_en};
    end else if (hit_mode) begin
      rd_mux[NX-1:0] = mode_sel;
    end else if (hit_stat) begin
      rd_mux[STAT_PEND0 +: N_CH] = pend;
    end else if (hit_code) begin
      rd_mux[15:0] = corrected_code[int'(aidx5) * 16 +: 16];
    end else if (hit_dual) begin
      rd_mux[15:0] = corrected_code[int'(aidx5) * 16 +: 16];
    end else if (hit_gain) begin
      rd_mux[15:0] = gain_mem[int'(aidx6)];
    end else if (hit_offs) begin
      rd_mux[15:0] = offs_mem[int'(aidx6)];
    end
  end

  // Accesses wait while a correction sequence runs, so a result is never
  // read half way through a dual-channel update.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_o && st == ST_IDLE) begin
      pready_o <= 1'b1;
      pslverr_o <= !(hit_ctrl || hit_mode || hit_stat || hit_code || hit_dual || hit_gain || hit_offs);
      prdata_o <= rd_mux;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and mode registers
  // ----------------------------------------------------------------
  // [RQ4] reset clears calibration enable
  // [RQ5] one enable for every DAC
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_en <= CAL_EN_RST;
      defer <= {N_CH{DEFER_RST}};
    end else if (acc_wr && hit_ctrl) begin
      cal_en <= pwdata_i[CTRL_CAL_EN];
      defer <= pwdata_i[CTRL_DEFER0 +: N_CH];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_sel <= '0;
    end else if (acc_wr && hit_mode) begin
      mode_sel <= pwdata_i[NX-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Coefficient store
  // ----------------------------------------------------------------
  // [RQ1] one word pair per function
  // [RQ3] no reset term here
  // [RQ12] results untouched by this
  always_ff @(posedge sys_clk_i) begin
    if (acc_wr && hit_gain) begin
      gain_mem[int'(aidx6)] <= pwdata_i[15:0];
    end
    if (acc_wr && hit_offs) begin
      offs_mem[int'(aidx6)] <= pwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Correction sequence
  // ----------------------------------------------------------------
  // [RQ14] set chosen at write time
  // Mode bits are captured with the raw code, so later mode changes do not
  // reach a sequence already under way.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_raw <= 16'h0000;
      cap_dac <= '0;
      cap_mask <= '0;
      cap_sel <= '0;
      cap_cal <= 1'b0;
    end else if (code_wr) begin
      cap_raw <= pwdata_i[15:0];
      cap_sel <= mode_sel;
      cap_cal <= cal_en;
      if (hit_dual) begin
        cap_dac <= DW'(aidx5);
        cap_mask <= 2'h3;
      end else begin
        cap_dac <= DW'(int'(aidx5) % N_DAC);
        cap_mask <= aidx5 >= ND5 ? 2'h2 : 2'h1;
      end
    end
  end

  assign sel_idx = (int'(cap_sel[int'(cur_ch) * N_DAC + int'(cap_dac)]) * N_CH + int'(cur_ch)) * N_DAC + int'(cap_dac);
  assign sel_m = gain_mem[sel_idx];
  assign sel_c = offs_mem[sel_idx];
  assign c_in_valid = st == ST_ISSUE;
  assign wr_slot = int'(cur_ch) * N_DAC + int'(cap_dac);

  // [RQ10] channel 0 first, then 1
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= ST_IDLE;
      cur_ch <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (code_wr) begin
            st <= ST_ISSUE;
            cur_ch <= hit_code && aidx5 >= ND5;
          end
        end
        ST_ISSUE: begin
          st <= ST_WAIT;
        end
        ST_WAIT: begin
          if (c_out_valid) begin
            if (!cur_ch && cap_mask[1]) begin
              st <= ST_ISSUE;
              cur_ch <= 1'b1;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // [RQ8] single result per DAC
  // [RQ11] updated only by code writes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      corrected_code <= '0;
    end else if (st == ST_WAIT && c_out_valid) begin
      corrected_code[wr_slot * 16 +: 16] <= c_code;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_done <= 1'b0;
    end else begin
      seq_done <= st == ST_WAIT && c_out_valid && !(!cur_ch && cap_mask[1]);
    end
  end

  dgoc_corr u_corr (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(c_in_valid),
    .bypass_i(!cap_cal),
    .raw_code_i(cap_raw),
    .m_i(sel_m),
    .c_i(sel_c),
    .out_valid_o(c_out_valid),
    .code_o(c_code)
  );

  // ----------------------------------------------------------------
  // Analog update per channel bank
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < N_CH; ch++) begin : g_bank
      assign ch_wr[ch] = st == ST_WAIT && c_out_valid && cur_ch == 1'(ch);

      dgoc_update u_upd (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .wr_i(ch_wr[ch]),
        .imm_i(!defer[ch]),
        .done_i(seq_done),
        .load_i(load_req[ch]),
        .xfer_o(xfer[ch]),
        .pend_o(pend[ch])
      );

      // [RQ8] result moves to the DAC
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          dac_code_o[ch * N_DAC * 16 +: N_DAC * 16] <= '0;
          dac_load_o[ch] <= 1'b0;
        end else begin
          dac_load_o[ch] <= xfer[ch];
          if (xfer[ch]) begin
            dac_code_o[ch * N_DAC * 16 +: N_DAC * 16] <= corrected_code[ch * N_DAC * 16 +: N_DAC * 16];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_cal_set: assert property ( // RQ4
    $rose(cal_en) |-> $past(acc_wr && hit_ctrl && pwdata_i[CTRL_CAL_EN]))
    else $error("calibration enabled without a control write");

  chk_result_written: assert property ( // RQ11
    !$stable(corrected_code) |-> $past(st == ST_WAIT && c_out_valid))
    else $error("result changed without a code write");

  chk_dual_order: assert property ( // RQ10
    st == ST_WAIT && c_out_valid && !cur_ch && cap_mask[1] |=> ##[1:3] (st == ST_WAIT && c_out_valid && cur_ch))
    else $error("dual write did not update channel 1 after channel 0");

  chk_read_result: assert property ( // RQ9
    psel_i && penable_i && pready_o && !pwrite_i && hit_code
    |-> prdata_o[15:0] == corrected_code[int'(aidx5) * 16 +: 16])
    else $error("readback differs from corrected code");

  cov_dual: cover property (code_wr && hit_dual ##[1:8] seq_done);
  cov_bypass: cover property (code_wr && !cal_en);
  cov_imm: cover property (seq_done ##1 xfer[0]);

endmodule

/* bench/dgoc_host.sv */
// Host model: an APB master that issues one read or write per call.
// Assumes the slave answers each access with a one-cycle pready pulse.
`timescale 1ns/1ns
module dgoc_host (
  input wire logic sys_clk_i,
  output logic [11:0] paddr_o,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial begin
    paddr_o = 12'hFFF;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    pwdata_o = 32'hA5A5A5A5;
  end

  // ----------------------------------------------------------------
  // Single transfer
  // ----------------------------------------------------------------
  // Address and data are inverted once released, so the slave can never
  // profit from a stale value left on an unselected bus.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    // Only the bench watchdog ends a wait that never gets an answer.
    do begin
      @(posedge sys_clk_i);
    end while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
    @(posedge sys_clk_i);
  endtask
endmodule

/* bench/dgoc_top_tb.sv */
// Self-checking bench for the DAC correction block.
// Assumes the host model in dgoc_host and the register map of dgoc_pkg.
`timescale 1ns/1ns
module dgoc_top_tb;
  import dgoc_pkg::*;
  localparam int ND = 4;
  logic sys_clk_i;
  logic resetn_i;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2*ND*16-1:0] dac_code;
  logic [1:0] dac_load;
  int err_total;
  int num_checks;
  int loads [2];
  logic [15:0] gm [2*N_SET*ND];
  logic [15:0] gc [2*N_SET*ND];
  logic [15:0] ex [2*ND];
  logic cal;
  logic [31:0] rd;
  logic re;

  dgoc_top #(.N_DAC(ND)) i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dac_code_o(dac_code), .dac_load_o(dac_load));
  dgoc_host i_host (.sys_clk_i(sys_clk_i), .paddr_o(paddr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (dac_load[0] === 1'b1) loads[0]++;
    if (dac_load[1] === 1'b1) loads[1]++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Truncating multiply, then clamp instead of wrapping.
  function automatic logic [15:0] corr(input logic [15:0] x, input logic [15:0] m, input logic [15:0] c);
    longint v;
    v = ((longint'(m) + 1) * longint'(x)) / 65536 + longint'(c) - 32768;
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return v[15:0];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, re);
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rd, re);
    chk(what, exp, rd);
  endtask
  task automatic coef(input int k, input logic [15:0] m, input logic [15:0] c);
    gm[k] = m;
    gc[k] = c;
    wr(GAIN_BASE + 12'(4 * k), {16'h0000, m});
    wr(OFFS_BASE + 12'(4 * k), {16'h0000, c});
  endtask
  task automatic code(input int ch, input int dac, input int set, input logic [15:0] x);
    int k;
    k = (set * 2 + ch) * ND + dac;
    ex[ch*ND+dac] = cal ? corr(x, gm[k], gc[k]) : x;
    wr(CODE_BASE + 12'(4 * (ch * ND + dac)), {16'h0000, x});
  endtask
  task automatic rcode(input int ch, input int dac);
    rchk("result", CODE_BASE + 12'(4 * (ch * ND + dac)), {16'h0000, ex[ch*ND+dac]});
  endtask
  task automatic settle();
    repeat (12) @(posedge sys_clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    loads = '{0, 0};
    cal = 1'b0;
    resetn_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    for (int k = 0; k < 2 * N_SET * ND; k++) begin
      rchk("gain", GAIN_BASE + 12'(4 * k), {16'h0000, GAIN_DEF});
      rchk("offs", OFFS_BASE + 12'(4 * k), {16'h0000, OFFS_DEF});
      coef(k, 16'h8000 + 16'(k * 'h0700), 16'h7F00 + 16'(k * 'h0030));
      rchk("gain", GAIN_BASE + 12'(4 * k), {16'h0000, gm[k]});
    end
    $display("test defaults done");
    for (int p = 0; p < 2; p++) begin
      cal = p[0];
      wr(ADDR_CTRL, {31'h0, cal});
      loads = '{0, 0};
      for (int i = 0; i < 2 * ND; i++) begin
        code(i / ND, i % ND, 0, 16'hF00D - 16'(i * (p + 1) * 'h1111));
        rcode(i / ND, i % ND);
      end
      settle();
      for (int i = 0; i < 2 * ND; i++) chk("dac code", {16'h0, ex[i]}, {16'h0, dac_code[i*16 +: 16]});
      chk("loads ch0", 32'd4, 32'(loads[0]));
      chk("loads ch1", 32'd4, 32'(loads[1]));
    end
    $display("test bypass and correction done");
    coef(0, 16'hFFFF, 16'h0000);
    code(0, 0, 0, 16'h0010);
    rcode(0, 0);
    coef(0, 16'hFFFF, 16'hFFFF);
    code(0, 0, 0, 16'hFFFF);
    rcode(0, 0);
    coef(0, GAIN_DEF, OFFS_DEF);
    code(0, 0, 0, 16'h1234);
    rcode(0, 0);
    coef(0, 16'h4000, 16'h9000);
    wr(ADDR_MODE, 32'h000000FF);
    coef(2 * ND, 16'hC000, 16'h8100);
    rcode(0, 0);
    code(0, 0, 1, 16'h8000);
    rcode(0, 0);
    $display("test saturate and mode done");
    wr(ADDR_MODE, 32'h0);
    for (int d = 0; d < ND; d++) begin
      ex[d] = corr(16'h6000 + 16'(d), gm[d], gc[d]);
      ex[ND+d] = corr(16'h6000 + 16'(d), gm[ND+d], gc[ND+d]);
      wr(DUAL_BASE + 12'(4 * d), {16'h0000, 16'h6000 + 16'(d)});
      rcode(0, d);
      rcode(1, d);
    end
    $display("test dual done");
    wr(ADDR_CTRL, 32'h3);
    settle();
    loads = '{0, 0};
    code(0, 1, 0, 16'h2468);
    settle();
    chk("deferred loads", 32'd0, 32'(loads[0]));
    rchk("pending", ADDR_STAT, 32'h1);
    wr(ADDR_CTRL, 32'h13);
    settle();
    chk("released loads", 32'd1, 32'(loads[0]));
    chk("dac code", {16'h0, ex[1]}, {16'h0, dac_code[16 +: 16]});
    rchk("pending", ADDR_STAT, 32'h0);
    i_host.xfer(1'b0, 12'hFFC, 32'h0, rd, re);
    chk("pslverr", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rd);
    $display("test deferred and refusal done");
    resetn_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    for (int k = 0; k < 2 * N_SET * ND; k++) begin
      rchk("gain", GAIN_BASE + 12'(4 * k), {16'h0000, gm[k]});
      rchk("offs", OFFS_BASE + 12'(4 * k), {16'h0000, gc[k]});
    end
    cal = 1'b0;
    code(1, 2, 0, 16'hABCD);
    rcode(1, 2);
    $display("test second reset done");
    give_verdict();
  end
endmodule
